// ### rtl/shp_pkg.sv
package shp_pkg;

    // Register offsets (5-bit address space).
    localparam logic [4:0] REG_CHIP_STATE_CTRL = 5'h00;
    localparam logic [4:0] REG_PROTOCOL_SELECT = 5'h01;
    localparam logic [4:0] REG_NO_REPLY_TIMEOUT = 5'h07;
    localparam logic [4:0] REG_RECEIVE_HOLDOFF = 5'h08;
    localparam logic [4:0] REG_MODULATION_CLOCK_CTRL = 5'h09;
    localparam logic [4:0] REG_RECEIVER_SPECIAL_CFG = 5'h0a;

    localparam logic [7:0] REG_RESET_VALUE = 8'h00;

    // Field positions.
    localparam int DIRECT_BIT_POS = 6;
    localparam int DIRECT_MODE_SEL_POS = 6;
    localparam int ADDR_CMD_POS = 7;
    localparam int ADDR_RD_POS = 6;
    localparam int ADDR_CONT_POS = 5;

    localparam int WORD_BITS = 8;
    localparam logic [2:0] LAST_BIT_IDX = 3'h7;
    localparam logic [4:0] ADDR_STEP = 5'h01;

    typedef enum logic [1:0] {
        SHP_ST_ADDR,
        SHP_ST_WRITE,
        SHP_ST_READ,
        SHP_ST_IGNORE
    } shp_state_t;

    // Decoded address word.
    typedef struct packed {
        logic is_cmd;
        logic is_read;
        logic cont;
        logic [4:0] addr;
    } shp_addr_word_t;

    // Register write request carried from the link domain.
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] data;
    } shp_wr_req_t;

endpackage

// ### rtl/shp_sync.sv
`timescale 1ns/1ns
`default_nettype none
module shp_sync (
    // Clock
    input wire logic clk,
    // Asynchronous level in, synchronised level out
    input wire logic d_in,
    output logic q_out
);
    logic meta_reg;
    logic sync_reg;

    always_ff @(posedge clk) begin
        meta_reg <= d_in;
        sync_reg <= meta_reg;
    end

    assign q_out = sync_reg;
endmodule
`default_nettype wire

// ### rtl/shp_serial_port.sv
`timescale 1ns/1ns
`default_nettype none
module shp_serial_port
    import shp_pkg::*;
(
    // System clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial link (clocked by the host serial clock)
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Direct mode pins
    input wire logic modulation_input,
    input wire logic subcarrier_env,
    input wire logic decoder_data,
    input wire logic decoder_clk,
    output logic tx_modulate,
    output logic rx_data_pin,
    output logic rx_data_pin_oe,
    output logic rx_clk_pin,
    output logic rx_clk_pin_oe,
    // Status towards the protocol core
    output logic direct_mode,
    output logic fifo_enable,
    output logic irq_enable,
    output logic framing_bypass,
    output logic [7:0] protocol_select_val,
    output logic [7:0] modulation_clock_val
);
    // ==========================================================
    // Link domain: shift engine on sclk, reset by ss_n
    // ==========================================================
    shp_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    shp_addr_word_t aw_reg;
    logic [7:0] rd_shift_reg;
    logic [7:0] rd_byte_next;
    logic wr_tgl_reg;
    shp_wr_req_t wr_req_reg;
    logic [7:0] word_now;
    logic [4:0] rd_addr;
    logic dm0_link;
    logic dm_link_sync;
    logic dm0_sel_link;

    assign word_now = {shift_reg, mosi};

    // The register file lives in the clk domain; read data is picked from
    // it directly, as it is quasi-static. Registers only change on link writes and on stop,
    // which happen before the read byte is sampled, so no tearing occurs.
    logic [7:0] reg_file [0:5];
    always_comb begin
        unique case (rd_addr)
            REG_CHIP_STATE_CTRL: rd_byte_next = reg_file[0];
            REG_PROTOCOL_SELECT: rd_byte_next = reg_file[1];
            REG_NO_REPLY_TIMEOUT: rd_byte_next = reg_file[2];
            REG_RECEIVE_HOLDOFF: rd_byte_next = reg_file[3];
            REG_MODULATION_CLOCK_CTRL: rd_byte_next = reg_file[4];
            REG_RECEIVER_SPECIAL_CFG: rd_byte_next = reg_file[5];
            default: rd_byte_next = REG_RESET_VALUE;
        endcase
    end

    // The address register already advances after each data byte when cont is set, so the load
    // for the next byte must use it as it stands.
    assign rd_addr = (state_reg == SHP_ST_ADDR) ? word_now[4:0]
                   : aw_reg.addr;

    // Direct mode level crossed into the link domain.
    shp_sync u_dm_sync (
        .clk(sclk),
        .d_in(dm0_sel_link),
        .q_out(dm_link_sync)
    );
    assign dm0_link = dm_link_sync;

    // Asynchronous reset by ss_n holds the engine idle while select is high.
    always_ff @(posedge sclk or posedge ss_n) begin
        if (ss_n) begin
            state_reg <= SHP_ST_ADDR;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
            aw_reg <= '0;
        end else begin
            shift_reg <= word_now[6:0];
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == LAST_BIT_IDX) begin
                unique case (state_reg)
                    SHP_ST_ADDR: begin
                        aw_reg <= shp_addr_word_t'(word_now);
                        if (word_now[ADDR_CMD_POS] || dm0_link)
                            state_reg <= SHP_ST_IGNORE;
                        else if (word_now[ADDR_RD_POS])
                            state_reg <= SHP_ST_READ;
                        else
                            state_reg <= SHP_ST_WRITE;
                    end
                    SHP_ST_WRITE, SHP_ST_READ: begin
                        // Bytes that follow the entering write in the
                        // same frame are refused once mode 0 is active.
                        if (dm0_link)
                            state_reg <= SHP_ST_IGNORE;
                        else if (aw_reg.cont)
                            aw_reg.addr <= aw_reg.addr + ADDR_STEP;
                    end
                    SHP_ST_IGNORE: state_reg <= SHP_ST_IGNORE;
                endcase
            end
        end
    end

    // Write request capture: toggle marks a new word for the clk domain.
    always_ff @(posedge sclk or posedge ss_n) begin
        if (ss_n) begin
            wr_tgl_reg <= 1'b0;
            wr_req_reg <= '0;
        end else if (bit_cnt_reg == LAST_BIT_IDX &&
                     state_reg == SHP_ST_WRITE && !dm0_link) begin
            wr_req_reg <= '{addr: aw_reg.addr, data: word_now};
            wr_tgl_reg <= ~wr_tgl_reg;
        end
    end

    // Read data launched on falling edges, half a cycle after B0 is taken.
    logic rd_load;
    assign rd_load = (bit_cnt_reg == 3'h0) && (state_reg == SHP_ST_READ);
    always_ff @(negedge sclk or posedge ss_n) begin
        if (ss_n) begin
            rd_shift_reg <= 8'h00;
        end else if (rd_load) begin
            rd_shift_reg <= rd_byte_next;
        end else begin
            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
        end
    end
    assign miso = rd_shift_reg[WORD_BITS-1];
    assign miso_oe = (state_reg == SHP_ST_READ) && !ss_n;

    // ==========================================================
    // System domain: register file and direct mode control
    // ==========================================================
    logic ss_sync;
    logic ss_prev_reg;
    logic tgl_sync;
    logic tgl_prev_reg;
    logic stop_evt;
    logic wr_evt;
    logic [4:0] wr_addr_s;
    logic [7:0] wr_data_s;
    shp_wr_req_t wr_hold_reg;

    shp_sync u_ss_sync (
        .clk(clk),
        .d_in(ss_n),
        .q_out(ss_sync)
    );
    shp_sync u_tgl_sync (
        .clk(clk),
        .d_in(wr_tgl_reg),
        .q_out(tgl_sync)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            ss_prev_reg <= 1'b1;
            tgl_prev_reg <= 1'b0;
        end else begin
            ss_prev_reg <= ss_sync;
            tgl_prev_reg <= ss_sync ? 1'b0 : tgl_sync;
        end
    end
    assign stop_evt = ss_sync && !ss_prev_reg;
    // The toggle data is stable for at least two clk cycles after the
    // toggle settles, since the host rests the serial clock for 400 ns after each byte.
    assign wr_evt = (tgl_sync != tgl_prev_reg) && !ss_sync;
    always_ff @(posedge clk) begin
        if (srst)
            wr_hold_reg <= '0;
        else
            wr_hold_reg <= wr_req_reg;
    end
    assign wr_addr_s = wr_hold_reg.addr;
    assign wr_data_s = wr_hold_reg.data;

    logic direct_reg;
    logic dm_sel_reg;
    assign dm0_sel_link = direct_reg && !reg_file[1][DIRECT_MODE_SEL_POS];

    genvar gi;
    localparam logic [4:0] REG_ADDRS [0:5] = '{REG_CHIP_STATE_CTRL,
        REG_PROTOCOL_SELECT, REG_NO_REPLY_TIMEOUT, REG_RECEIVE_HOLDOFF,
        REG_MODULATION_CLOCK_CTRL, REG_RECEIVER_SPECIAL_CFG};
    generate
        for (gi = 0; gi < 6; gi++) begin : g_regs
            always_ff @(posedge clk) begin
                if (srst)
                    reg_file[gi] <= REG_RESET_VALUE;
                else if (gi == 0 && stop_evt)
                    reg_file[gi][DIRECT_BIT_POS] <= 1'b0;
                else if (wr_evt && wr_addr_s == REG_ADDRS[gi])
                    reg_file[gi] <= wr_data_s;
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            direct_reg <= 1'b0;
            dm_sel_reg <= 1'b0;
        end else if (stop_evt) begin
            direct_reg <= 1'b0;
        end else if (wr_evt && wr_addr_s == REG_CHIP_STATE_CTRL) begin
            direct_reg <= wr_data_s[DIRECT_BIT_POS];
            dm_sel_reg <= reg_file[1][DIRECT_MODE_SEL_POS];
        end
    end

    // Direct mode pin routing; pins are quiet outside direct mode.
    always_comb begin
        tx_modulate = 1'b0;
        rx_data_pin = 1'b0;
        rx_clk_pin = 1'b0;
        rx_data_pin_oe = 1'b0;
        rx_clk_pin_oe = 1'b0;
        if (direct_reg) begin
            tx_modulate = modulation_input;
            rx_data_pin_oe = 1'b1;
            if (!dm_sel_reg) begin
                rx_data_pin = subcarrier_env;
            end else begin
                rx_data_pin = decoder_data;
                rx_clk_pin = decoder_clk;
                rx_clk_pin_oe = 1'b1;
            end
        end
    end

    assign direct_mode = direct_reg;
    assign fifo_enable = !direct_reg;
    assign irq_enable = !direct_reg;
    // Mode 1 keeps frame delimiters; only the core's framer is bypassed.
    assign framing_bypass = direct_reg;
    assign protocol_select_val = reg_file[1];
    assign modulation_clock_val = reg_file[4];

    // ==========================================================
    // Checks
    // ==========================================================
    stop_clears_a: assert property (@(posedge clk) disable iff (srst)
        stop_evt |=> !direct_reg && !reg_file[0][DIRECT_BIT_POS])
        else $error("stop did not leave direct mode");
    direct_enter_a: assert property (@(posedge clk) disable iff (srst)
        wr_evt && !stop_evt && wr_addr_s == REG_CHIP_STATE_CTRL
        && wr_data_s[DIRECT_BIT_POS] |=> direct_reg)
        else $error("direct bit write did not enter direct mode");
    no_fifo_irq_a: assert property (@(posedge clk) disable iff (srst)
        direct_reg |-> !fifo_enable && !irq_enable)
        else $error("fifo or irq enabled in direct mode");
    mode0_route_a: assert property (@(posedge clk) disable iff (srst)
        direct_reg && !dm_sel_reg |-> rx_data_pin == subcarrier_env
        && tx_modulate == modulation_input)
        else $error("mode 0 routing wrong");
    mode1_route_a: assert property (@(posedge clk) disable iff (srst)
        direct_reg && dm_sel_reg |-> rx_clk_pin == decoder_clk
        && rx_data_pin == decoder_data)
        else $error("mode 1 routing wrong");
    idle_pins_a: assert property (@(posedge clk) disable iff (srst)
        !direct_reg |-> !tx_modulate && !rx_data_pin_oe)
        else $error("direct pins active outside direct mode");
    miso_quiet_a: assert property (@(posedge sclk) disable iff (ss_n)
        state_reg == SHP_ST_WRITE |-> !miso_oe && !miso)
        else $error("data-out driven during write");
    cnt_wrap_a: assert property (@(posedge sclk) disable iff (ss_n)
        bit_cnt_reg == LAST_BIT_IDX |=> bit_cnt_reg == 3'h0)
        else $error("bit counter did not wrap after eight");
    refuse_dm0_a: assert property (@(posedge sclk) disable iff (ss_n)
        state_reg == SHP_ST_ADDR && bit_cnt_reg == LAST_BIT_IDX && dm0_link
        |=> state_reg == SHP_ST_IGNORE)
        else $error("register access accepted in mode 0");

    enter_c: cover property (@(posedge clk) disable iff (srst)
        !direct_reg ##1 direct_reg);
    exit_c: cover property (@(posedge clk) disable iff (srst)
        direct_reg ##1 !direct_reg);
    read_c: cover property (@(posedge sclk) disable iff (ss_n)
        state_reg == SHP_ST_READ);
endmodule
`default_nettype wire

// ### verif/shp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module shp_host_model (
    // Serial link
    output logic sclk,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end

    task automatic start();
        ss_n <= 1'b0;
        #48;
    endtask

    // The clock rests low between bytes so each byte can cross domains.
    task automatic xfer(input int n, input logic [7:0] tx,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            mosi <= tx[i];
            #24 sclk <= 1'b1;
            #1 rx[i] = miso;
            #23 sclk <= 1'b0;
        end
        #400;
    endtask

    // The idle data line flips so a stale level never passes for data.
    task automatic stop();
        #800 ss_n <= 1'b1;
        mosi <= ~mosi;
        #400;
    endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import shp_pkg::*;
    logic clk, srst, sclk, ss_n, mosi, miso, miso_oe;
    logic mod_in, env, dec_d, dec_c, tx_mod, rxd, rxd_oe, rxc, rxc_oe;
    logic direct_mode, fifo_enable, irq_enable, framing_bypass;
    logic [7:0] psel, mclk, rb;
    int fails = 0;
    int checks_done = 0;

    shp_serial_port uut (.clk(clk), .srst(srst), .sclk(sclk),
        .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .modulation_input(mod_in), .subcarrier_env(env),
        .decoder_data(dec_d), .decoder_clk(dec_c), .tx_modulate(tx_mod),
        .rx_data_pin(rxd), .rx_data_pin_oe(rxd_oe), .rx_clk_pin(rxc),
        .rx_clk_pin_oe(rxc_oe), .direct_mode(direct_mode),
        .fifo_enable(fifo_enable), .irq_enable(irq_enable),
        .framing_bypass(framing_bypass), .protocol_select_val(psel),
        .modulation_clock_val(mclk));
    shp_host_model host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi),
        .miso(miso));

    // ====================================================
    // Clock, checks and verdict
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk8(input string nm, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic end_of_test();
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        fails++;
        end_of_test();
    end

    // ====================================================
    // Link helpers
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.start();
        host.xfer(8, {3'b000, a}, rb);
        chk1("miso_oe in write", 1'b0, miso_oe);
        host.xfer(8, d, rb);
        host.stop();
    endtask

    task automatic rd(input logic [4:0] a, input int n,
                      input logic [7:0] e0, e1);
        host.start();
        host.xfer(8, {2'b01, n > 1, a}, rb);
        chk1("miso_oe in read", 1'b1, miso_oe);
        host.xfer(8, 8'h00, rb);
        chk8("read byte", e0, rb);
        if (n > 1) begin
            host.xfer(8, 8'h00, rb);
            chk8("next read byte", e1, rb);
        end
        host.stop();
    endtask

    task automatic wait_dm(input logic v);
        for (int i = 0; i < 20 && direct_mode !== v; i++) @(posedge clk);
        chk1("direct_mode", v, direct_mode);
    endtask

    // Leaves the frame open: a stop would end direct mode at once.
    task automatic enter();
        wr(REG_MODULATION_CLOCK_CTRL, 8'h61);
        host.start();
        host.xfer(8, {3'b000, REG_CHIP_STATE_CTRL}, rb);
        host.xfer(8, 8'h40, rb);
        wait_dm(1'b1);
        chk1("fifo_enable", 1'b0, fifo_enable);
        chk1("irq_enable", 1'b0, irq_enable);
        chk1("framing_bypass", 1'b1, framing_bypass);
        chk1("rx_data_pin_oe", 1'b1, rxd_oe);
    endtask

    task automatic pins(input logic m1);
        logic [3:0] p;
        for (int i = 0; i < 4; i++) begin
            p = {i[0], ~i[0], i[1], ~i[1]};
            @(posedge clk);
            {mod_in, env, dec_d, dec_c} <= p;
            @(negedge clk);
            chk1("tx_modulate", p[3], tx_mod);
            chk1("rx_data_pin", m1 ? p[1] : p[2], rxd);
            if (m1) begin
                chk1("rx_clk_pin", p[0], rxc);
            end
        end
    endtask

    // ====================================================
    // Scenarios
    task automatic t_reset();
        chk8("protocol_select_val", REG_RESET_VALUE, psel);
        chk8("modulation_clock_val", REG_RESET_VALUE, mclk);
        chk1("direct_mode", 1'b0, direct_mode);
        chk1("fifo_enable", 1'b1, fifo_enable);
        chk1("miso_oe idle", 1'b0, miso_oe);
    endtask

    task automatic t_codes();
        logic [23:0] ps;
        ps = {8'h08, 8'h1A, 8'h1B};
        for (int i = 0; i < 3; i++) begin
            wr(REG_PROTOCOL_SELECT, ps[8*i+:8]);
            chk8("protocol_select_val", ps[8*i+:8], psel);
        end
        for (int v = 32; v < 38; v++) begin
            wr(REG_MODULATION_CLOCK_CTRL, 8'(v));
            chk8("modulation_clock_val", 8'(v), mclk);
        end
    endtask

    task automatic t_cont();
        host.start();
        host.xfer(8, {3'b001, REG_NO_REPLY_TIMEOUT}, rb);
        host.xfer(8, 8'h0E, rb);
        host.xfer(8, 8'h07, rb);
        host.stop();
        rd(REG_NO_REPLY_TIMEOUT, 2, 8'h0E, 8'h07);
        rd(5'h1F, 1, 8'h00, 8'h00);
    endtask

    task automatic t_partial();
        host.start();
        host.xfer(5, 8'hFF, rb);
        host.stop();
        wr(REG_PROTOCOL_SELECT, 8'h1A);
        chk8("protocol_select_val", 8'h1A, psel);
    endtask

    task automatic t_direct0();
        wr(REG_PROTOCOL_SELECT, 8'h08);
        enter();
        chk1("rx_clk_pin_oe", 1'b0, rxc_oe);
        pins(1'b0);
        host.xfer(8, {3'b000, REG_PROTOCOL_SELECT}, rb);
        host.xfer(8, 8'hFF, rb);
        repeat (8) @(posedge clk);
        chk8("protocol_select_val", 8'h08, psel);
        chk1("direct_mode held", 1'b1, direct_mode);
        host.stop();
        wait_dm(1'b0);
        rd(REG_CHIP_STATE_CTRL, 1, 8'h00, 8'h00);
        chk1("fifo_enable", 1'b1, fifo_enable);
    endtask

    task automatic t_direct1();
        wr(REG_PROTOCOL_SELECT, 8'h48);
        enter();
        chk1("rx_clk_pin_oe", 1'b1, rxc_oe);
        pins(1'b1);
        host.stop();
        wait_dm(1'b0);
    endtask

    task automatic t_cmd();
        host.start();
        host.xfer(8, 8'h8F, rb);
        host.xfer(8, {3'b000, REG_PROTOCOL_SELECT}, rb);
        host.xfer(8, 8'h00, rb);
        host.stop();
        chk8("protocol_select_val", 8'h48, psel);
    endtask

    initial begin
        srst = 1'b1;
        {mod_in, env, dec_d, dec_c} = 4'h0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_codes();
        t_cont();
        t_partial();
        t_direct0();
        t_direct1();
        t_cmd();
        end_of_test();
    end
endmodule
`default_nettype wire
